//--- logic/sewb_top.sv
`timescale 1ns/1ps
`default_nettype none

module sewb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic             full;
  logic             empty;

  assign full      = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
  assign empty     = (wr_ptr == rd_ptr);
  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = store[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && !full) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      if (in_valid && !full) begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    (in_valid && !full) |=> !empty) else $error("fifo lost a pushed word");
endmodule : sewb_fifo

module sewb_top #(
  parameter int PROG_CYCLES = sewb_pkg::PROG_CYCLES
) (
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst_n,
  // Two-wire bus pins
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  // Straps
  input  wire logic       select_pin_bit0,
  input  wire logic       select_pin_bit1,
  input  wire logic       select_pin_bit2,
  input  wire logic       write_protect,
  // Status
  output logic            prog_busy
);
  localparam int PACE_CYCLES = PROG_CYCLES / sewb_pkg::PACE_DIV;

  logic [1:0]                       rst_sync;
  logic                             rst_n_i;
  logic [sewb_pkg::SYNC_BITS-1:0]   sync1;
  logic [sewb_pkg::SYNC_BITS-1:0]   sync2;
  logic                             scl_d;
  logic                             sda_d;
  logic                             scl_s;
  logic                             sda_s;
  logic [2:0]                       sel_s;
  logic                             wp_s;
  logic                             scl_rise;
  logic                             scl_fall;
  logic                             start_evt;
  logic                             stop_evt;
  sewb_pkg::sewb_state_t            state;
  logic [3:0]                       bit_cnt;
  logic [7:0]                       shreg;
  logic                             rw_read;
  logic                             first_byte;
  logic                             master_ack;
  logic [7:0]                       ptr;
  logic [7:0]                       mem [sewb_pkg::MEM_BYTES];
  logic [7:0]                       pg_data [sewb_pkg::PAGE_BYTES];
  logic [sewb_pkg::PAGE_BYTES-1:0]  pg_valid;
  logic                             addr_match;
  logic                             commit_active;
  logic [3:0]                       commit_idx;
  logic                             push_valid;
  logic                             push_ready;
  logic                             drain_valid;
  logic [15:0]                      drain_data;
  logic [31:0]                      prog_cnt;
  logic [31:0]                      pace_cnt;
  logic                             pace_en;
  logic                             pg_take;
  logic                             pg_clear;

  // Reset release is synchronised so that every flop leaves reset on one edge.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n_i = rst_sync[1];

  // All pins come from outside this clock domain.
  always_ff @(posedge core_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1 <= 6'h03;
      sync2 <= 6'h03;
    end else begin
      sync1 <= {write_protect, select_pin_bit2, select_pin_bit1, select_pin_bit0, sda_in, scl_in};
      sync2 <= sync1;
    end
  end
  assign scl_s = sync2[0];
  assign sda_s = sync2[1];
  assign sel_s = sync2[4:2];
  assign wp_s  = sync2[5];

  always_ff @(posedge core_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign scl_rise  = scl_s && !scl_d;
  assign scl_fall  = !scl_s && scl_d;
  assign start_evt = scl_s && scl_d && sda_d && !sda_s;
  assign stop_evt  = scl_s && scl_d && !sda_d && sda_s;
  assign addr_match = (shreg[7:4] == sewb_pkg::TYPE_CODE)
                      && (shreg[3:1] == sel_s);
  assign pg_take  = (state == sewb_pkg::ST_WR_BYTE) && scl_fall
                    && (bit_cnt == 4'h8) && !first_byte;
  // A committing STOP must keep the valid bits, or the commit would find nothing to push.
  assign pg_clear = (stop_evt && !prog_busy && (wp_s || ~|pg_valid))
                    || (commit_active && (commit_idx == 4'hF) && (push_ready || !pg_valid[4'hF]));

  // Bus protocol engine; it only moves on synchronised SCL edges and conditions.
  always_ff @(posedge core_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state      <= sewb_pkg::ST_IDLE;
      bit_cnt    <= 4'h0;
      shreg      <= 8'h00;
      rw_read    <= 1'b0;
      first_byte <= 1'b0;
      master_ack <= 1'b0;
      sda_oe     <= 1'b0;
    end else if (stop_evt) begin
      state  <= sewb_pkg::ST_IDLE;
      sda_oe <= 1'b0;
    end else if (start_evt) begin
      // A busy device behaves as absent so the master can poll it.
      state   <= prog_busy ? sewb_pkg::ST_IDLE : sewb_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'b0;
    end else begin
      unique case (state)
        sewb_pkg::ST_IDLE, sewb_pkg::ST_IGNORE: begin
          sda_oe <= 1'b0;
        end
        sewb_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            if (addr_match) begin
              state   <= sewb_pkg::ST_ACK_ADDR;
              sda_oe  <= 1'b1;
              rw_read <= shreg[0];
            end else begin
              state <= sewb_pkg::ST_IGNORE;
            end
          end
        end
        sewb_pkg::ST_ACK_ADDR: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (rw_read) begin
              state  <= sewb_pkg::ST_RD_BYTE;
              shreg  <= mem[ptr];
              sda_oe <= !mem[ptr][7];
            end else begin
              state      <= sewb_pkg::ST_WR_BYTE;
              first_byte <= 1'b1;
              sda_oe     <= 1'b0;
            end
          end
        end
        sewb_pkg::ST_WR_BYTE: begin
          if (scl_rise) begin
            shreg   <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            state      <= sewb_pkg::ST_ACK_WR;
            sda_oe     <= 1'b1;
            first_byte <= 1'b0;
          end
        end
        sewb_pkg::ST_ACK_WR: begin
          if (scl_fall) begin
            state   <= sewb_pkg::ST_WR_BYTE;
            bit_cnt <= 4'h0;
            sda_oe  <= 1'b0;
          end
        end
        sewb_pkg::ST_RD_BYTE: begin
          if (scl_rise) begin
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall) begin
            if (bit_cnt == 4'h8) begin
              state  <= sewb_pkg::ST_RD_ACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= !shreg[3'h7 - bit_cnt[2:0]];
            end
          end
        end
        sewb_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            master_ack <= !sda_s;
          end else if (scl_fall) begin
            if (master_ack) begin
              state   <= sewb_pkg::ST_RD_BYTE;
              bit_cnt <= 4'h0;
              shreg   <= mem[ptr];
              sda_oe  <= !mem[ptr][7];
            end else begin
              state <= sewb_pkg::ST_IGNORE;
            end
          end
        end
      endcase
    end
  end

  // Address pointer: loaded by the first written byte, page-local on writes, full on reads.
  always_ff @(posedge core_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr <= 8'h00;
    end else if (state == sewb_pkg::ST_WR_BYTE && scl_fall && bit_cnt == 4'h8) begin
      if (first_byte) begin
        ptr <= shreg;
      end else begin
        ptr <= {ptr[7:4], ptr[3:0] + 4'h1};
      end
    end else if (scl_fall && ((state == sewb_pkg::ST_ACK_ADDR && rw_read)
                 || (state == sewb_pkg::ST_RD_ACK && master_ack))) begin
      ptr <= ptr + 8'h01;
    end
  end

  // Page buffer; a later byte at the same offset simply replaces the earlier one.
  always_ff @(posedge core_clk) begin
    if (pg_take) begin
      pg_data[ptr[3:0]] <= shreg;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pg_valid <= '0;
    end else if (pg_clear) begin
      pg_valid <= '0;
    end else if (pg_take) begin
      pg_valid[ptr[3:0]] <= 1'b1;
    end
  end

  // Commit: at STOP every buffered page byte is queued toward the array in one program cycle.
  always_ff @(posedge core_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      commit_active <= 1'b0;
      commit_idx    <= 4'h0;
    end else if (stop_evt && !prog_busy && (|pg_valid) && !wp_s) begin
      commit_active <= 1'b1;
      commit_idx    <= 4'h0;
    end else if (commit_active && (push_ready || !pg_valid[commit_idx])) begin
      commit_idx <= commit_idx + 4'h1;
      if (commit_idx == 4'hF) begin
        commit_active <= 1'b0;
      end
    end
  end
  assign push_valid = commit_active && pg_valid[commit_idx];

  // Busy window is timed from the STOP; outputs must not drive SDA meanwhile.
  always_ff @(posedge core_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prog_busy <= 1'b0;
      prog_cnt  <= 32'h0000_0000;
    end else if (!prog_busy) begin
      prog_cnt <= 32'h0000_0000;
      if (stop_evt && (|pg_valid) && !wp_s) begin
        prog_busy <= 1'b1;
      end
    end else begin
      prog_cnt <= prog_cnt + 32'h0000_0001;
      if (prog_cnt >= 32'(PROG_CYCLES - 2) && !commit_active && !drain_valid) begin
        prog_busy <= 1'b0;
      end
    end
  end

  // Slow pace for array writes, standing in for the cell programming rate.
  always_ff @(posedge core_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pace_cnt <= 32'h0000_0000;
      pace_en  <= 1'b0;
    end else if (pace_cnt >= 32'(PACE_CYCLES - 1)) begin
      pace_cnt <= 32'h0000_0000;
      pace_en  <= 1'b1;
    end else begin
      pace_cnt <= pace_cnt + 32'h0000_0001;
      pace_en  <= 1'b0;
    end
  end

  sewb_fifo #(
    .WIDTH (sewb_pkg::FIFO_WIDTH),
    .DEPTH (sewb_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (core_clk),
    .rst_n     (rst_n_i),
    .in_valid  (push_valid),
    .in_ready  (push_ready),
    .in_data   ({ptr[7:4], commit_idx, pg_data[commit_idx]}),
    .out_valid (drain_valid),
    .out_ready (pace_en),
    .out_data  (drain_data)
  );

  always_ff @(posedge core_clk) begin
    if (drain_valid && pace_en) begin
      mem[drain_data[15:8]] <= drain_data[7:0];
    end
  end

  // SDA is open drain: the data level is always low, only the enable moves.
  always_ff @(posedge core_clk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_out <= 1'b0;
    end else begin
      sda_out <= 1'b0;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n_i);

  busy_start_a: assert property (stop_evt && !prog_busy && (|pg_valid) && !wp_s |=> prog_busy)
    else $error("program cycle did not start at stop");
  busy_len_a: assert property (prog_busy |-> prog_cnt < 32'(PROG_CYCLES))
    else $error("program cycle overran its time");
  busy_quiet_a: assert property (prog_busy && $past(prog_busy) |-> !sda_oe)
    else $error("sda driven while programming");
  wp_block_a: assert property (stop_evt && wp_s && !prog_busy |=> !prog_busy && !commit_active)
    else $error("protected write started programming");
  addr_miss_a: assert property (state == sewb_pkg::ST_ADDR && scl_fall && bit_cnt == 4'h8 && !stop_evt
    && !start_evt && !addr_match |=> state == sewb_pkg::ST_IGNORE && !sda_oe)
    else $error("mismatched address not ignored");
  addr_ack_a: assert property (state == sewb_pkg::ST_ADDR && scl_fall && bit_cnt == 4'h8 && !stop_evt
    && !start_evt && addr_match |=> sda_oe && state == sewb_pkg::ST_ACK_ADDR)
    else $error("matching address not acknowledged");
  start_seen_a: assert property (start_evt && !stop_evt && !prog_busy |=> state == sewb_pkg::ST_ADDR)
    else $error("start not detected");
  stop_idle_a: assert property (stop_evt |=> state == sewb_pkg::ST_IDLE)
    else $error("stop did not end the transfer");
  page_wrap_a: assert property (pg_take |=> ptr[7:4] == $past(ptr[7:4])
    && ptr[3:0] == $past(ptr[3:0]) + 4'h1)
    else $error("page address left its page");
  busy_poll_a: assert property (start_evt && prog_busy |=> state == sewb_pkg::ST_IDLE)
    else $error("busy device answered a poll");
endmodule : sewb_top

`default_nettype wire

//--- logic/sewb_pkg.sv
// Notes on behaviour
// - Programming starts at the write STOP and ends within 5 ms.
// - While programming, SDA stays released and the own address gets no acknowledge.
// - START is SDA falling while SCL high; nothing is heeded before one.
// - STOP is SDA rising while SCL high; every operation ends with it.
// - SDA changes only while SCL is low; changes while high are START or STOP.
// - Respond only when the top four address bits equal 1010.
// - Address bits three to one must equal the three select pins.
// - Address bit zero picks read when 1 and write when 0.
// - The receiver pulls SDA low on the ninth clock to acknowledge.
// - A write-selected device acknowledges the byte address and every data byte.
// - Read sends 8 bits, samples the acknowledge, continues or stops until STOP.
// - First written byte loads the address pointer; data goes to that location.
// - Programming starts only at the STOP after write data.
// - Up to 16 data bytes per write cycle go into a page buffer.
// - Each data byte advances only the low four address bits.
// - More than 16 bytes wrap in the page and overwrite earlier ones.
// - At STOP all buffered page bytes are programmed in one cycle.
// - Polling address gets no acknowledge while busy, an acknowledge once done.
// - Write protect high protects the whole array; low allows writes.
// - SDA is only pulled low or released, never driven high.
// - Pointer holds last accessed address plus one, wrapping after 255 on reads and within the 16-byte page on writes.
// - Sequential reads advance all eight address bits, wrapping after 256 bytes.
package sewb_pkg;
  localparam logic [3:0] TYPE_CODE     = 4'hA;
  localparam int         PAGE_BYTES    = 16;
  localparam int         MEM_BYTES     = 256;
  localparam int         FIFO_DEPTH    = 32;
  localparam int         FIFO_WIDTH    = 16;
  localparam int         CLK_MHZ       = 125;
  localparam int         PROG_TIME_US  = 5000;
  // Longest time rounds down to whole cycles.
  localparam int         PROG_CYCLES   = PROG_TIME_US * CLK_MHZ;
  // Drain pace leaves half the program window free as margin.
  localparam int         PACE_DIV      = 32;
  localparam int         BITS_PER_BYTE = 8;
  localparam int         SYNC_BITS     = 6;

  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_ADDR     = 3'h1,
    ST_ACK_ADDR = 3'h3,
    ST_WR_BYTE  = 3'h2,
    ST_ACK_WR   = 3'h6,
    ST_RD_BYTE  = 3'h7,
    ST_RD_ACK   = 3'h5,
    ST_IGNORE   = 3'h4
  } sewb_state_t;
endpackage : sewb_pkg

//--- tb/sewb_master.sv
`timescale 1ns/1ps
`default_nettype none

module sewb_master (
  // Clock
  input  wire logic core_clk,
  // Bus lines
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda_wire
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
  endtask : wt

  // A repeated start lifts SDA while SCL is low, so it cannot look like a stop.
  task automatic start();
    sda_low <= 1'b0;
    wt(4);
    scl <= 1'b1;
    wt(8);
    sda_low <= 1'b1;
    wt(8);
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    wt(4);
    sda_low <= 1'b1;
    wt(4);
    scl <= 1'b1;
    wt(8);
    sda_low <= 1'b0;
    wt(8);
  endtask : stop

  // SDA moves a quarter period after SCL falls and is sampled at the end of the high phase.
  task automatic bit_io(input logic b, output logic r);
    wt(4);
    sda_low <= !b;
    wt(4);
    scl <= 1'b1;
    wt(8);
    r = sda_wire;
    scl <= 1'b0;
  endtask : bit_io

  task automatic byte_wr(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], r);
    end
    bit_io(1'b1, r);
    ack = !r;
  endtask : byte_wr

  task automatic byte_rd(input logic ack_it, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!ack_it, r);
  endtask : byte_rd
endmodule : sewb_master

`default_nettype wire

//--- tb/sewb_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module sewb_top_tb_top;
  localparam int PROG_CYC = 2000;
  logic       core_clk;
  logic       rst_n;
  logic       scl;
  logic       sda_low;
  logic       sda_wire;
  logic       sda_out;
  logic       sda_oe;
  logic       write_protect;
  logic       prog_busy;
  logic [2:0] sel;
  logic       oe_seen;
  int         busy_len;
  int         last_len;
  int         error_cnt;
  int         checks_done;

  // Open-drain line with a pull-up: high unless someone pulls it low.
  assign sda_wire = !(sda_low || sda_oe);

  sewb_top #(.PROG_CYCLES(PROG_CYC)) u_sewb_top (
    .core_clk        (core_clk),
    .rst_n           (rst_n),
    .scl_in          (scl),
    .sda_in          (sda_wire),
    .sda_out         (sda_out),
    .sda_oe          (sda_oe),
    .select_pin_bit0 (sel[0]),
    .select_pin_bit1 (sel[1]),
    .select_pin_bit2 (sel[2]),
    .write_protect   (write_protect),
    .prog_busy       (prog_busy)
  );

  sewb_master u_sewb_master (
    .core_clk (core_clk),
    .scl      (scl),
    .sda_low  (sda_low),
    .sda_wire (sda_wire)
  );

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = !core_clk;
  end

  // Each busy window is counted whole; its length is kept once it ends.
  always @(posedge core_clk) begin
    if (prog_busy === 1'b1) begin
      busy_len <= busy_len + 1;
    end else if (busy_len != 0) begin
      last_len <= busy_len;
      busy_len <= 0;
    end
    if (sda_oe === 1'b1) oe_seen <= 1'b1;
  end

  task automatic chk_bit(input logic got, input logic exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : chk_bit

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp, input string msg);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk_byte

  function automatic logic [7:0] sa(input logic rd);
    return {4'b1010, sel, rd};
  endfunction : sa

  task automatic wr(input logic [7:0] a, input logic [7:0] d[$]);
    logic ack;
    u_sewb_master.start();
    u_sewb_master.byte_wr(sa(1'b0), ack);
    chk_bit(ack, 1'b1, "write address ack");
    u_sewb_master.byte_wr(a, ack);
    chk_bit(ack, 1'b1, "byte address ack");
    foreach (d[i]) begin
      u_sewb_master.byte_wr(d[i], ack);
      chk_bit(ack, 1'b1, "data ack");
    end
    chk_bit(prog_busy, 1'b0, "busy before stop");
    u_sewb_master.stop();
  endtask : wr

  task automatic rd(input logic [7:0] a, input int n, output logic [7:0] q[$]);
    logic       ack;
    logic [7:0] b;
    q = {};
    u_sewb_master.start();
    u_sewb_master.byte_wr(sa(1'b0), ack);
    u_sewb_master.byte_wr(a, ack);
    u_sewb_master.start();
    u_sewb_master.byte_wr(sa(1'b1), ack);
    chk_bit(ack, 1'b1, "read address ack");
    for (int i = 0; i < n; i++) begin
      u_sewb_master.byte_rd(i < n - 1, b);
      q.push_back(b);
    end
    u_sewb_master.stop();
  endtask : rd

  // Waits out a program cycle and checks its length against the bound.
  task automatic wait_prog();
    last_len = 0;
    for (int i = 0; i < PROG_CYC + 50 && prog_busy === 1'b1; i++) u_sewb_master.wt(1);
    u_sewb_master.wt(2);
    chk_bit(last_len > 0 && last_len < PROG_CYC, 1'b1, "program cycle length");
  endtask : wait_prog

  task automatic t_byte_write();
    logic       ack;
    logic [7:0] q[$];
    wr(8'h35, {8'hA7});
    u_sewb_master.wt(2);
    chk_bit(prog_busy, 1'b1, "busy after stop");
    chk_bit(sda_out, 1'b0, "sda data level");
    u_sewb_master.start();
    u_sewb_master.byte_wr(sa(1'b0), ack);
    chk_bit(ack, 1'b0, "poll while busy");
    u_sewb_master.stop();
    wait_prog();
    u_sewb_master.start();
    u_sewb_master.byte_wr(sa(1'b0), ack);
    chk_bit(ack, 1'b1, "poll after done");
    u_sewb_master.stop();
    rd(8'h35, 1, q);
    chk_byte(q[0], 8'hA7, "byte readback");
    $display("t_byte_write done");
  endtask : t_byte_write

  task automatic t_page_wrap();
    logic [7:0] d[$];
    logic [7:0] e[16];
    logic [7:0] q[$];
    logic       ack;
    logic [7:0] b;
    for (int i = 0; i < 18; i++) begin
      d.push_back(8'h60 + 8'(i));
      e[(8 + i) % 16] = 8'h60 + 8'(i);
    end
    wr(8'h48, d);
    u_sewb_master.wt(2);
    wait_prog();
    // The last byte went to offset 9, so a read without a byte address starts at offset 10.
    u_sewb_master.start();
    u_sewb_master.byte_wr(sa(1'b1), ack);
    u_sewb_master.byte_rd(1'b0, b);
    u_sewb_master.stop();
    chk_byte(b, e[10], "immediate read");
    rd(8'h40, 16, q);
    for (int i = 0; i < 16; i++) chk_byte(q[i], e[i], "page byte");
    $display("t_page_wrap done");
  endtask : t_page_wrap

  task automatic t_mismatch();
    logic [7:0] bad[2];
    logic       ack;
    bad[0] = {4'b1011, sel, 1'b0};
    bad[1] = {4'b1010, ~sel, 1'b0};
    foreach (bad[i]) begin
      oe_seen = 1'b0;
      u_sewb_master.start();
      u_sewb_master.byte_wr(bad[i], ack);
      u_sewb_master.byte_wr(8'h00, ack);
      chk_bit(oe_seen, 1'b0, "mismatch drove sda");
      u_sewb_master.stop();
      chk_bit(prog_busy, 1'b0, "mismatch programmed");
    end
    $display("t_mismatch done");
  endtask : t_mismatch

  task automatic t_protect();
    logic [7:0] q[$];
    write_protect <= 1'b1;
    u_sewb_master.wt(8);
    wr(8'h35, {8'h11});
    u_sewb_master.wt(4);
    chk_bit(prog_busy, 1'b0, "protected busy");
    write_protect <= 1'b0;
    rd(8'h35, 1, q);
    chk_byte(q[0], 8'hA7, "protected readback");
    $display("t_protect done");
  endtask : t_protect

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  initial begin
    rst_n         = 1'b0;
    write_protect = 1'b0;
    sel           = 3'b101;
    oe_seen       = 1'b0;
    busy_len      = 0;
    last_len      = 0;
    error_cnt     = 0;
    checks_done   = 0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (10) @(posedge core_clk);
    t_byte_write();
    t_page_wrap();
    t_mismatch();
    t_protect();
    close_out();
  end

  // The tests need about 13000 cycles; 40000 means a hang.
  initial begin
    #320_000;
    error_cnt++;
    close_out();
  end
endmodule : sewb_top_tb_top

`default_nettype wire
